// >>> dnbac_pkg.sv
package dnbac_pkg;
    // --------------------------------------------------------------
    // bank 0 special function offsets
    // --------------------------------------------------------------
    localparam logic [7:0] OFS_INDPORT = 8'h02;
    localparam logic [7:0] OFS_INDPTR = 8'h03;
    localparam logic [7:0] OFS_BANK = 8'h04;
    localparam logic [7:0] OFS_IRQ = 8'h2e;
    localparam logic [7:0] OFS_POINTER = 8'h2f;
    localparam logic [7:0] OFS_BUFFER = 8'h30;
    // --------------------------------------------------------------
    // indirect location of the control register
    // --------------------------------------------------------------
    localparam logic [7:0] CTRL_LOC = 8'h40;
    localparam logic [7:0] CTRL_BANK = 8'h01;
    // --------------------------------------------------------------
    // control register fields
    // --------------------------------------------------------------
    localparam int CTRL_FETCH_TRIG = 0;
    localparam int CTRL_FETCH_PERMIT = 1;
    localparam int CTRL_PROG_TRIG = 2;
    localparam int CTRL_PROG_PERMIT = 3;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // --------------------------------------------------------------
    // interrupt register fields
    // --------------------------------------------------------------
    localparam int IRQ_COMP_PERMIT = 0;
    localparam int IRQ_MF_PERMIT = 1;
    localparam int IRQ_COMP_FLAG = 2;
    localparam int IRQ_MF_FLAG = 3;
    localparam logic [7:0] BANK_RESET = 8'h00;
    // --------------------------------------------------------------
    // timing
    // --------------------------------------------------------------
    localparam int READ_CYCLES = 2;
    localparam int PROG_TICKS = 64;
    localparam int DEF_ADDR_W = 8;
    typedef enum logic [1:0] {DNBAC_IDLE, DNBAC_FETCH, DNBAC_PROGRAM} dnbac_state_t;
endpackage

// >>> dnbac_engine_if.sv
`timescale 1ns/1ps
interface dnbac_engine_if #(parameter int ADDR_W = 8) (input wire logic clk);
    logic fetch_go;
    logic program_go;
    logic [ADDR_W-1:0] loc;
    logic [7:0] wbyte;
    logic done;
    logic [7:0] rbyte;
    modport ctrl (output fetch_go, output program_go, output loc, output wbyte,
        input done, input rbyte);
    modport engine (input fetch_go, input program_go, input loc, input wbyte,
        output done, output rbyte);
endinterface

// >>> dnbac_engine.sv
`timescale 1ns/1ps
module dnbac_engine import dnbac_pkg::*; #(
    parameter int ADDR_W = DEF_ADDR_W,
    parameter int TICKS = PROG_TICKS
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic osc_tick,
    dnbac_engine_if.engine eng
);
    localparam int DEPTH = 1 << ADDR_W;
    localparam int RD_LAT = READ_CYCLES;

    typedef struct packed {
        dnbac_state_t state;
        logic [15:0] cnt;
        logic [ADDR_W-1:0] loc;
        logic [7:0] wbyte;
        logic tick_s1;
        logic tick_s2;
        logic tick_s3;
        logic done;
        logic [7:0] rbyte;
    } dnbac_eng_t;

    dnbac_eng_t r;
    dnbac_eng_t next_r;
    logic [7:0] cells [DEPTH];
    logic tick_edge;

    // --------------------------------------------------------------
    // timing engine
    // --------------------------------------------------------------
    // the program timer runs off a free oscillator, so only its synchronised rising edges count
    assign tick_edge = r.tick_s2 && !r.tick_s3;

    always_comb begin
        next_r = r;
        next_r.tick_s1 = osc_tick;
        next_r.tick_s2 = r.tick_s1;
        next_r.tick_s3 = r.tick_s2;
        next_r.done = 1'b0;
        case (r.state)
            DNBAC_IDLE: begin
                next_r.loc = eng.loc;
                next_r.wbyte = eng.wbyte;
                next_r.cnt = '0;
                if (eng.program_go) begin
                    next_r.state = DNBAC_PROGRAM;
                end else if (eng.fetch_go) begin
                    next_r.state = DNBAC_FETCH;
                end
            end
            DNBAC_FETCH: begin
                next_r.cnt = r.cnt + 16'h0001;
                if (r.cnt == 16'(RD_LAT - 1)) begin
                    next_r.rbyte = cells[r.loc];
                    next_r.done = 1'b1;
                    next_r.state = DNBAC_IDLE;
                end
            end
            DNBAC_PROGRAM: begin
                if (tick_edge) begin
                    next_r.cnt = r.cnt + 16'h0001;
                    if (r.cnt == 16'(TICKS - 1)) begin
                        next_r.done = 1'b1;
                        next_r.state = DNBAC_IDLE;
                    end
                end
            end
            default: next_r.state = DNBAC_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // cells are not reset: contents are non-volatile
    always_ff @(posedge clk) begin
        if (r.state == DNBAC_PROGRAM && next_r.done) begin
            cells[r.loc] <= r.wbyte;
        end
    end

    assign eng.done = r.done;
    assign eng.rbyte = r.rbyte;

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence fetch_start_s;
        r.state == DNBAC_IDLE && eng.fetch_go && !eng.program_go;
    endsequence

    read_latency_a: assert property (fetch_start_s |-> ##3 r.done)
        else $error("fetch did not finish in fixed time");
    prog_not_early_a: assert property (
        r.state == DNBAC_IDLE && eng.program_go |=> !r.done [*3])
        else $error("program cycle ended before the timer ran");
endmodule

// >>> dnbac_ctrl.sv
`timescale 1ns/1ps
// Behaviour
// - pointer width follows capacity, upper bits zero
// - control upper four bits read zero
// - program permit cleared at power-on
// - program permit zero blocks every write
// - program trigger starts write only when permitted
// - hardware clears program trigger when write ends
// - fetch permit zero blocks every read
// - fetch trigger starts read only when permitted
// - read end clears trigger, loads byte buffer
// - byte buffer holds until next operation
// - write timed by independent timer, completion signalled
// - cycle end sets completion and multi-function flags
// - vector needs all enables and stack room
// - service clears multi-function flag only
// - bank selector resets to bank zero
// - control reached indirectly at location 40h bank 1
// - capacity 32 to 256 bytes, byte addressed
module dnbac_ctrl import dnbac_pkg::*; #(
    parameter int ADDR_W = DEF_ADDR_W,
    parameter int TICKS = PROG_TICKS
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic global_irq_enable,
    input wire logic stack_full,
    input wire logic irq_service,
    output logic mf_vector_req,
    input wire logic osc_tick
);
    typedef struct packed {
        logic [7:0] bank_selector;
        logic [7:0] indirect_pointer;
        logic [ADDR_W-1:0] nvm_location_pointer;
        logic [7:0] nvm_byte_buffer;
        logic program_permit;
        logic program_trig;
        logic fetch_permit;
        logic fetch_trig;
        logic completion_irq_permit;
        logic mf_irq_permit;
        logic completion_request_flag;
        logic mf_request_flag;
        logic go_prog;
        logic go_fetch;
        logic [7:0] rdata;
    } dnbac_regs_t;

    dnbac_regs_t r;
    dnbac_regs_t next_r;
    logic ctrl_hit;
    logic busy;

    dnbac_engine_if #(.ADDR_W(ADDR_W)) eng (.clk(clk));

    dnbac_engine #(.ADDR_W(ADDR_W), .TICKS(TICKS)) u_engine (
        .clk(clk),
        .resetn(resetn),
        .osc_tick(osc_tick),
        .eng(eng.engine)
    );

    // --------------------------------------------------------------
    // decode
    // --------------------------------------------------------------
    function automatic logic is_ctrl(input logic [7:0] a, input logic [7:0] ptr,
        input logic [7:0] bank);
        is_ctrl = (a == OFS_INDPORT) && (ptr == CTRL_LOC) && (bank == CTRL_BANK);
    endfunction

    function automatic logic [7:0] ctrl_view(input dnbac_regs_t s);
        ctrl_view = 8'h00;
        ctrl_view[CTRL_PROG_PERMIT] = s.program_permit;
        ctrl_view[CTRL_PROG_TRIG] = s.program_trig;
        ctrl_view[CTRL_FETCH_PERMIT] = s.fetch_permit;
        ctrl_view[CTRL_FETCH_TRIG] = s.fetch_trig;
    endfunction

    assign ctrl_hit = is_ctrl(sfr_addr, r.indirect_pointer, r.bank_selector);
    // one cycle at a time; a running trigger locks out new ones
    assign busy = r.program_trig || r.fetch_trig;

    // --------------------------------------------------------------
    // register behaviour
    // --------------------------------------------------------------
    always_comb begin
        logic want_prog;
        logic want_fetch;
        logic [7:0] irq_view;
        want_prog = 1'b0;
        want_fetch = 1'b0;
        irq_view = 8'h00;
        next_r = r;
        next_r.go_prog = 1'b0;
        next_r.go_fetch = 1'b0;

        if (sfr_wr) begin
            case (sfr_addr)
                OFS_BANK: next_r.bank_selector = sfr_wdata;
                OFS_INDPTR: next_r.indirect_pointer = sfr_wdata;
                OFS_POINTER: next_r.nvm_location_pointer = sfr_wdata[ADDR_W-1:0];
                OFS_BUFFER: next_r.nvm_byte_buffer = sfr_wdata;
                OFS_IRQ: begin
                    next_r.completion_irq_permit = sfr_wdata[IRQ_COMP_PERMIT];
                    next_r.mf_irq_permit = sfr_wdata[IRQ_MF_PERMIT];
                    // software may only clear the flags
                    if (!sfr_wdata[IRQ_COMP_FLAG]) begin
                        next_r.completion_request_flag = 1'b0;
                    end
                    if (!sfr_wdata[IRQ_MF_FLAG]) begin
                        next_r.mf_request_flag = 1'b0;
                    end
                end
                default: ;
            endcase
            if (ctrl_hit) begin
                next_r.program_permit = sfr_wdata[CTRL_PROG_PERMIT];
                next_r.fetch_permit = sfr_wdata[CTRL_FETCH_PERMIT];
                // permit must already be one before the trigger counts
                want_prog = sfr_wdata[CTRL_PROG_TRIG] && r.program_permit;
                want_fetch = sfr_wdata[CTRL_FETCH_TRIG] && r.fetch_permit;
                // both triggers at once is illegal; refuse both rather than guess
                if (!busy && !(sfr_wdata[CTRL_PROG_TRIG] && sfr_wdata[CTRL_FETCH_TRIG])) begin
                    if (want_prog) begin
                        next_r.program_trig = 1'b1;
                        next_r.go_prog = 1'b1;
                    end else if (want_fetch) begin
                        next_r.fetch_trig = 1'b1;
                        next_r.go_fetch = 1'b1;
                    end
                end
            end
        end

        if (irq_service) begin
            next_r.mf_request_flag = 1'b0;
        end

        // completion: set wins over any clear in the same cycle
        if (eng.done) begin
            if (r.fetch_trig) begin
                next_r.nvm_byte_buffer = eng.rbyte;
            end
            next_r.program_trig = 1'b0;
            next_r.fetch_trig = 1'b0;
            next_r.completion_request_flag = 1'b1;
            next_r.mf_request_flag = 1'b1;
        end

        irq_view[IRQ_COMP_PERMIT] = r.completion_irq_permit;
        irq_view[IRQ_MF_PERMIT] = r.mf_irq_permit;
        irq_view[IRQ_COMP_FLAG] = r.completion_request_flag;
        irq_view[IRQ_MF_FLAG] = r.mf_request_flag;

        if (sfr_rd) begin
            if (ctrl_hit) begin
                next_r.rdata = ctrl_view(r);
            end else begin
                case (sfr_addr)
                    OFS_BANK: next_r.rdata = r.bank_selector;
                    OFS_INDPTR: next_r.rdata = r.indirect_pointer;
                    OFS_POINTER: next_r.rdata = 8'(r.nvm_location_pointer);
                    OFS_BUFFER: next_r.rdata = r.nvm_byte_buffer;
                    OFS_IRQ: next_r.rdata = irq_view;
                    default: next_r.rdata = 8'h00;
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            r <= '0;
            r.bank_selector <= BANK_RESET;
            r.program_permit <= CTRL_RESET[CTRL_PROG_PERMIT];
        end else begin
            r <= next_r;
        end
    end

    // --------------------------------------------------------------
    // outputs
    // --------------------------------------------------------------
    assign eng.program_go = r.go_prog;
    assign eng.fetch_go = r.go_fetch;
    assign eng.loc = r.nvm_location_pointer;
    assign eng.wbyte = r.nvm_byte_buffer;
    assign sfr_rdata = r.rdata;
    assign mf_vector_req = r.mf_request_flag && r.mf_irq_permit && r.completion_irq_permit
        && global_irq_enable && !stack_full;

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence ctrl_write_s;
        sfr_wr && ctrl_hit && !busy;
    endsequence

    ptr_upper_zero_a: assert property (
        sfr_rd && !ctrl_hit && sfr_addr == OFS_POINTER |=> (sfr_rdata >> ADDR_W) == 8'h00)
        else $error("pointer upper bits not zero");
    ctrl_upper_zero_a: assert property (
        sfr_rd && ctrl_hit |=> sfr_rdata[7:4] == 4'h0 && sfr_rdata == $past(ctrl_view(r)))
        else $error("control read back wrong");
    permit_reset_a: assert property (disable iff (1'b0)
        !resetn |=> !r.program_permit && !r.program_trig && r.bank_selector == 8'h00)
        else $error("reset left write path armed");
    prog_blocked_a: assert property (
        ctrl_write_s and !r.program_permit |=> !r.go_prog && !r.program_trig)
        else $error("write started without permit");
    prog_start_a: assert property (
        ctrl_write_s and sfr_wdata[CTRL_PROG_TRIG] && !sfr_wdata[CTRL_FETCH_TRIG]
        && r.program_permit |=> r.program_trig && r.go_prog ##1 !r.go_prog)
        else $error("permitted write did not start");
    fetch_blocked_a: assert property (
        ctrl_write_s and !r.fetch_permit |=> !r.go_fetch && !r.fetch_trig)
        else $error("read started without permit");
    fetch_start_a: assert property (
        ctrl_write_s and sfr_wdata[CTRL_FETCH_TRIG] && !sfr_wdata[CTRL_PROG_TRIG]
        && r.fetch_permit |=> r.fetch_trig [*4] ##1 !r.fetch_trig)
        else $error("permitted read did not run");
    trig_clear_a: assert property (
        eng.done |=> !r.program_trig && !r.fetch_trig)
        else $error("trigger not cleared at end of cycle");
    buffer_load_a: assert property (
        eng.done && r.fetch_trig |=> r.nvm_byte_buffer == $past(eng.rbyte))
        else $error("fetched byte not in buffer");
    buffer_hold_a: assert property (
        !eng.done && !(sfr_wr && sfr_addr == OFS_BUFFER) |=> $stable(r.nvm_byte_buffer))
        else $error("buffer changed without cause");
    flags_set_a: assert property (
        eng.done |=> r.completion_request_flag && r.mf_request_flag)
        else $error("completion flags not raised");
    vector_gate_a: assert property (
        mf_vector_req |-> global_irq_enable && !stack_full && r.completion_irq_permit
        && r.mf_irq_permit)
        else $error("vector requested while gated");
    service_clear_a: assert property (
        irq_service && !eng.done && !(sfr_wr && sfr_addr == OFS_IRQ)
        |=> !r.mf_request_flag && r.completion_request_flag == $past(r.completion_request_flag))
        else $error("service cleared the wrong flag");
    busy_ignore_a: assert property (
        sfr_wr && ctrl_hit && busy |=> !r.go_prog && !r.go_fetch)
        else $error("trigger accepted during a cycle");

    // --------------------------------------------------------------
    // checks on the cause of every change
    // --------------------------------------------------------------
    permit_store_a: assert property (
        sfr_wr && ctrl_hit |=> r.program_permit == $past(sfr_wdata[CTRL_PROG_PERMIT])
        && r.fetch_permit == $past(sfr_wdata[CTRL_FETCH_PERMIT]))
        else $error("permit bits not stored");
    ctrl_guard_a: assert property (
        !(sfr_wr && ctrl_hit) |=> $stable(r.program_permit) && $stable(r.fetch_permit))
        else $error("control changed outside its indirect location");
    ptr_store_a: assert property (
        sfr_wr && sfr_addr == OFS_POINTER
        |=> r.nvm_location_pointer == $past(sfr_wdata[ADDR_W-1:0]))
        else $error("pointer did not take the written address");
    dual_trig_a: assert property (
        sfr_wr && ctrl_hit && sfr_wdata[CTRL_PROG_TRIG] && sfr_wdata[CTRL_FETCH_TRIG]
        |=> !r.go_prog && !r.go_fetch)
        else $error("both triggers accepted together");
    prog_keeps_buf_a: assert property (
        eng.done && r.program_trig && !(sfr_wr && sfr_addr == OFS_BUFFER)
        |=> $stable(r.nvm_byte_buffer))
        else $error("buffer changed by a write cycle");
    sw_clear_a: assert property (
        sfr_wr && sfr_addr == OFS_IRQ && !sfr_wdata[IRQ_COMP_FLAG] && !eng.done
        |=> !r.completion_request_flag)
        else $error("software could not clear completion flag");
    one_go_a: assert property (
        r.go_prog |-> !r.go_fetch)
        else $error("read and write started together");

    sequence fetch_go_s;
        r.go_fetch;
    endsequence

    sequence fetch_end_s;
        eng.done && r.fetch_trig;
    endsequence

    // go is registered, the engine adds one cycle of entry and two of latency
    fetch_end_a: assert property (
        fetch_go_s |-> ##3 fetch_end_s ##1 !r.fetch_trig)
        else $error("read cycle did not end on time");
    flag_cause_a: assert property (
        !eng.done |=> !$rose(r.completion_request_flag) && !$rose(r.mf_request_flag))
        else $error("request flag raised without a finished cycle");
    trig_cause_a: assert property (
        !(sfr_wr && ctrl_hit) |=> !$rose(r.program_trig) && !$rose(r.fetch_trig))
        else $error("trigger rose without a control write");
endmodule

// >>> tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin \
    n_checks++; \
    if ((got) !== (exp)) begin \
        bad_count++; \
        $display("ERROR %s expected %h seen %h", nm, exp, got); \
    end \
end

module tb_top import dnbac_pkg::*; ;
    localparam int AW = 5;
    localparam int TK = 3;
    localparam int LIMIT = 20000;

    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic [7:0] sfr_addr = 8'h00;
    logic [7:0] sfr_wdata = 8'h00;
    logic [7:0] sfr_rdata;
    logic global_irq_enable = 1'b0;
    logic stack_full = 1'b0;
    logic irq_service = 1'b0;
    logic mf_vector_req;
    logic osc_tick = 1'b0;
    int bad_count = 0;
    int n_checks = 0;
    int cyc = 0;
    logic [7:0] v;

    dnbac_ctrl #(.ADDR_W(AW), .TICKS(TK)) dut_u (
        .clk(clk),
        .resetn(resetn),
        .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd),
        .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata),
        .global_irq_enable(global_irq_enable),
        .stack_full(stack_full),
        .irq_service(irq_service),
        .mf_vector_req(mf_vector_req),
        .osc_tick(osc_tick)
    );

    always #12.5 clk = ~clk;
    // program timer runs free, period chosen so it drifts against clk
    always #61.3 osc_tick = ~osc_tick;

    // --------------------------------------------------------------
    // register access
    // --------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr_wr <= 1'b1;
        sfr_addr <= a;
        sfr_wdata <= d;
        @(posedge clk);
        sfr_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        sfr_rd <= 1'b1;
        sfr_addr <= a;
        @(posedge clk);
        sfr_rd <= 1'b0;
        #1 d = sfr_rdata;
    endtask

    task automatic ctl(input logic [7:0] d);
        wr(OFS_INDPORT, d);
    endtask

    // polls the control register; bounded so a stuck trigger cannot hang
    task automatic wait_idle(input int b, output logic [7:0] d);
        int i;
        for (i = 0; i < 100; i++) begin
            rd(OFS_INDPORT, d);
            if (d[b] === 1'b0) break;
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // --------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------
    task automatic t_reset();
        rd(OFS_BANK, v);
        `CHK("bank after reset", BANK_RESET, v)
        wr(OFS_INDPTR, CTRL_LOC);
        ctl(8'h0a);
        wr(OFS_BANK, CTRL_BANK);
        rd(OFS_INDPORT, v);
        `CHK("control via bank 0", CTRL_RESET, v)
        `CHK("control unreachable", 8'h00, v)
        rd(8'h40, v);
        `CHK("direct control read", 8'h00, v)
    endtask

    task automatic t_ptr_ctrl();
        wr(OFS_POINTER, 8'hff);
        rd(OFS_POINTER, v);
        `CHK("pointer upper bits", 8'h1f, v)
        ctl(8'hf6);
        rd(OFS_INDPORT, v);
        `CHK("control upper bits", 8'h02, v)
        `CHK("trigger w/o permit", 1'b0, v[CTRL_PROG_TRIG])
    endtask

    task automatic t_program();
        wr(OFS_POINTER, 8'hff);
        wr(OFS_BUFFER, 8'h5a);
        ctl(8'h08);
        ctl(8'h0c);
        rd(OFS_INDPORT, v);
        `CHK("write running", 8'h0c, v)
        ctl(8'h0b);
        rd(OFS_INDPORT, v);
        `CHK("fetch while busy", 8'h0e, v)
        wait_idle(CTRL_PROG_TRIG, v);
        `CHK("write end", 8'h0a, v)
        rd(OFS_BUFFER, v);
        `CHK("buffer after write", 8'h5a, v)
        rd(OFS_IRQ, v);
        `CHK("flags after write", 8'h0c, v)
    endtask

    task automatic t_blocked();
        wr(OFS_IRQ, 8'h00);
        ctl(8'h02);
        wr(OFS_BUFFER, 8'ha5);
        ctl(8'h06);
        rd(OFS_INDPORT, v);
        `CHK("write refused", 8'h02, v)
        repeat (40) @(posedge clk);
        rd(OFS_IRQ, v);
        `CHK("no cycle ran", 8'h00, v)
    endtask

    task automatic t_fetch();
        ctl(8'h00);
        ctl(8'h01);
        rd(OFS_INDPORT, v);
        `CHK("fetch refused", 8'h00, v)
        `CHK("fetch trigger ignored", 1'b0, v[CTRL_FETCH_TRIG])
        wr(OFS_POINTER, 8'h1f);
        ctl(8'h02);
        ctl(8'h03);
        wait_idle(CTRL_FETCH_TRIG, v);
        `CHK("fetch end", 8'h02, v)
        rd(OFS_BUFFER, v);
        `CHK("fetched byte", 8'h5a, v)
        `CHK("top location kept", 8'h5a, v)
        repeat (10) @(posedge clk);
        rd(OFS_BUFFER, v);
        `CHK("buffer held", 8'h5a, v)
        rd(OFS_IRQ, v);
        `CHK("flags after fetch", 8'h0c, v)
    endtask

    task automatic t_irq();
        wr(OFS_IRQ, 8'h0f);
        @(posedge clk);
        global_irq_enable <= 1'b1;
        @(posedge clk);
        #1 `CHK("vector request", 1'b1, mf_vector_req)
        @(posedge clk);
        stack_full <= 1'b1;
        @(posedge clk);
        #1 `CHK("stack full gate", 1'b0, mf_vector_req)
        @(posedge clk);
        stack_full <= 1'b0;
        global_irq_enable <= 1'b0;
        @(posedge clk);
        #1 `CHK("global gate", 1'b0, mf_vector_req)
        @(posedge clk);
        global_irq_enable <= 1'b1;
        irq_service <= 1'b1;
        @(posedge clk);
        irq_service <= 1'b0;
        rd(OFS_IRQ, v);
        `CHK("service clears mf", 8'h07, v)
        `CHK("request dropped", 1'b0, mf_vector_req)
        wr(OFS_IRQ, 8'h03);
        rd(OFS_IRQ, v);
        `CHK("software clear", 8'h03, v)
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            bad_count++;
            close_out();
        end
    end

    initial begin
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        t_reset();
        t_ptr_ctrl();
        t_program();
        t_blocked();
        t_fetch();
        t_irq();
        close_out();
    end
endmodule
